// >>> hdl/sfc_frame_check.sv
// Serial slave with modulo-8 frame check, error flag and word buffer.
// Notes on behaviour
// - Full-duplex serial slave on serial out, serial in, serial clock, low select.
// - Select falling starts a new access and a new transfer.
// - Serial input captured on falling clock; serial output updated on rising clock.
// - Clock edges counted modulo 8; data accepted only on whole bytes.
// - Bad or zero count at select rise sets error flag, drops command.
// - Valid select rise delivers shift register contents to the word buffer.
// - Select high ignores clock and input, output floats.
// - Select falling loads response information into the shift register.
// - After select falls output drives error flag OR input until first rise.
// - Input words arrive most significant bit first, control bits first.
// - Response shifts out most significant bit first after each rising clock.
// - One frame is eight clocks; chains shift eight bits per device.
// - Bit leaving the shift register appears on output to feed a chain.
`timescale 1ns/1ps
`include "sfc_regs.svh"
module sfc_frame_check
  import sfc_pkg::*;
(
  input  wire logic      ref_clk_in,
  input  wire logic      srst_in,
  input  wire logic      clk_en_in,
  input  wire logic      sclk_in,
  input  wire logic      cs_n_in,
  input  wire logic      si_in,
  output logic           so_out,
  output logic           so_oe_out,
  input  wire sfc_byte_t resp_data_in,
  output logic           word_valid_out,
  input  wire logic      word_ready_in,
  output sfc_byte_t      word_data_out,
  output logic           frame_error_flag_out,
  output logic           overrun_out
);
  // Link domain: runs on the serial clock; select acts as its async reset.
  // The master holds the clock low around select edges, so select edges
  // never race a clock edge.
  sfc_byte_t             shift_reg;
  logic [`SFC_CNT_W-1:0] cnt_reg;
  logic                  bytes_reg;
  logic                  fill_reg;
  logic                  out_bit_reg;
  logic                  started_reg;
  logic                  good_reg;

  // System-domain state that the link side reads as a quasi-static level.
  sfc_byte_t             resp_reg, resp_next;
  logic                  flag_reg, flag_next;
  logic                  pre_bit_reg;

  // System domain: synchronisers for the pin levels and the link-domain verdict and word.
  logic                  cs_sync1_reg, cs_sync2_reg, cs_prev_reg;
  logic                  si_sync1_reg, si_sync2_reg;
  logic                  good_sync1_reg, good_sync2_reg;
  sfc_byte_t             word_sync1_reg, word_sync2_reg;

  // Capture on falling clock, count modulo 8, whole-byte marker.
  // The response is held in the system domain from the select fall on; the
  // master's lead time to the first clock must exceed three system cycles.
  always_ff @(negedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      cnt_reg   <= '0;
      bytes_reg <= 1'b0;
      fill_reg  <= 1'b0;
    end else begin
      if (!fill_reg) begin
        shift_reg <= {resp_reg[`SFC_FRAME_MSB-1:0], si_in};
        fill_reg  <= 1'b1;
      end else begin
        shift_reg <= {shift_reg[`SFC_FRAME_MSB-1:0], si_in};
      end
      cnt_reg   <= cnt_reg + 3'h1;
      bytes_reg <= (cnt_reg == 3'h7);
    end
  end

  // Update output on rising clock with the bit leaving the far end.
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      started_reg <= 1'b0;
      out_bit_reg <= 1'b0;
    end else begin
      started_reg <= 1'b1;
      if (!fill_reg) begin
        out_bit_reg <= resp_reg[`SFC_FRAME_MSB];
      end else begin
        out_bit_reg <= shift_reg[`SFC_FRAME_MSB];
      end
    end
  end

  // Verdict of the access, taken on the select rise before the same edge
  // clears the counters; it stays put while select is high.
  always_ff @(posedge cs_n_in) begin
    good_reg <= bytes_reg && (cnt_reg == 3'h0);
  end

  // Before the first rising clock the pin shows the system-domain value;
  // after it the link flop drives the pin, because the serial clock may
  // run faster than the system clock could follow.
  assign so_out = started_reg ? out_bit_reg : pre_bit_reg;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      so_oe_out   <= 1'b0;
      pre_bit_reg <= 1'b0;
    end else if (clk_en_in) begin
      so_oe_out   <= ~cs_sync2_reg;
      pre_bit_reg <= flag_reg | si_sync2_reg;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      cs_sync1_reg <= 1'b1;
      cs_sync2_reg <= 1'b1;
    end else if (clk_en_in) begin
      cs_sync1_reg      <= cs_n_in;
      cs_sync2_reg      <= cs_sync1_reg;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (clk_en_in) begin
      si_sync1_reg      <= si_in;
      si_sync2_reg      <= si_sync1_reg;
      good_sync1_reg    <= good_reg;
      good_sync2_reg    <= good_sync1_reg;
      word_sync1_reg    <= shift_reg;
      word_sync2_reg    <= word_sync1_reg;
    end
  end

  // Frame state machine in the system domain. The shift register and the
  // verdict are stable while select is high, so sampling them a few
  // cycles after the synchronised rise is safe.
  sfc_state_t state_reg, state_next;
  logic       cs_prev_next;
  logic       push_valid;
  logic       buf_ready;
  logic       ovr_reg, ovr_next;
  logic [1:0] wait_reg, wait_next;
  logic       buf_valid;
  sfc_byte_t  buf_data;

  always_comb begin
    state_next   = state_reg;
    flag_next    = flag_reg;
    resp_next    = resp_reg;
    ovr_next     = ovr_reg;
    wait_next    = wait_reg;
    push_valid   = 1'b0;
    cs_prev_next = cs_sync2_reg;
    case (state_reg)
      SFC_IDLE: begin
        if (cs_prev_reg && !cs_sync2_reg) begin
          state_next = SFC_SHIFT;
          resp_next  = resp_data_in;
        end
      end
      SFC_SHIFT: begin
        if (cs_sync2_reg) begin
          state_next = SFC_CLOSE;
          wait_next  = 2'h2;
        end
      end
      SFC_CLOSE: begin
        if (wait_reg != 2'h0) begin
          wait_next = wait_reg - 2'h1;
        end else begin
          state_next = SFC_IDLE;
          if (good_sync2_reg) begin
            push_valid = 1'b1;
            flag_next  = 1'b0;
            if (!buf_ready) begin
              ovr_next = 1'b1;
            end
          end else begin
            flag_next = 1'b1;
          end
        end
      end
      default: begin
        state_next = SFC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state_reg   <= SFC_IDLE;
      flag_reg    <= `SFC_FLAG_RST;
      resp_reg    <= `SFC_RESP_RST;
      ovr_reg     <= 1'b0;
      wait_reg    <= 2'h0;
      cs_prev_reg <= 1'b1;
    end else if (clk_en_in) begin
      state_reg   <= state_next;
      flag_reg    <= flag_next;
      resp_reg    <= resp_next;
      ovr_reg     <= ovr_next;
      wait_reg    <= wait_next;
      cs_prev_reg <= cs_prev_next;
    end
  end

  // The buffer pops exactly when the output stage takes, so no word is
  // handed over twice.
  logic stage_free;
  logic take;
  assign stage_free = !word_valid_out || word_ready_in;
  assign take       = buf_valid && stage_free;

  // A stalled receiver fills the output stage and both buffer entries; a
  // fourth frame with no room is counted as overrun rather than silently
  // overwriting a held word.
  sfc_buf2 u_buf (
    .ref_clk_in    (ref_clk_in),
    .srst_in       (srst_in),
    .clk_en_in     (clk_en_in),
    .in_valid_in   (push_valid),
    .in_ready_out  (buf_ready),
    .in_data_in    (word_sync2_reg),
    .out_valid_out (buf_valid),
    .out_ready_in  (stage_free),
    .out_data_out  (buf_data)
  );

  // Output stage register: takes a word from the buffer when empty or drained.
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      word_valid_out       <= 1'b0;
      word_data_out        <= `SFC_RESP_RST;
      frame_error_flag_out <= `SFC_FLAG_RST;
      overrun_out          <= 1'b0;
    end else if (clk_en_in) begin
      if (take) begin
        word_valid_out <= 1'b1;
        word_data_out  <= buf_data;
      end else if (word_ready_in) begin
        word_valid_out <= 1'b0;
      end
      frame_error_flag_out <= flag_reg;
      overrun_out          <= ovr_reg;
    end
  end
endmodule // sfc_frame_check

// >>> hdl/sfc_regs.svh
// Constants of the serial frame checker: frame layout and reset values.
`ifndef SFC_REGS_SVH
`define SFC_REGS_SVH
`define SFC_FRAME_BITS     8
`define SFC_CNT_W          3
`define SFC_FRAME_MSB      7
`define SFC_RESP_RST       8'h00
`define SFC_FLAG_RST       1'b0
`define SFC_BUF_DEPTH      2
`endif

// >>> hdl/sfc_pkg.sv
// Types shared by the serial frame checker files.
package sfc_pkg;
  typedef logic [7:0] sfc_byte_t;
  typedef enum logic [1:0] {
    SFC_IDLE  = 2'b00,
    SFC_SHIFT = 2'b01,
    SFC_CLOSE = 2'b10
  } sfc_state_t;
endpackage

// >>> hdl/sfc_buf2.sv
// Two-entry valid/ready buffer for received frame words.
`timescale 1ns/1ps
`include "sfc_regs.svh"
module sfc_buf2
  import sfc_pkg::*;
(
  input  wire logic      ref_clk_in,
  input  wire logic      srst_in,
  input  wire logic      clk_en_in,
  input  wire logic      in_valid_in,
  output logic           in_ready_out,
  input  wire sfc_byte_t in_data_in,
  output logic           out_valid_out,
  input  wire logic      out_ready_in,
  output sfc_byte_t      out_data_out
);
  sfc_byte_t mem_reg [`SFC_BUF_DEPTH];
  sfc_byte_t mem_next [`SFC_BUF_DEPTH];
  logic      wp_reg, wp_next, rp_reg, rp_next;
  logic [1:0] cnt_reg, cnt_next;
  logic      push, pop;

  assign push          = in_valid_in && (cnt_reg != 2'h2);
  assign pop           = (cnt_reg != 2'h0) && out_ready_in;
  assign in_ready_out  = (cnt_reg != 2'h2);
  assign out_valid_out = (cnt_reg != 2'h0);
  assign out_data_out  = mem_reg[rp_reg];

  always_comb begin
    mem_next = mem_reg;
    wp_next  = wp_reg;
    rp_next  = rp_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wp_reg] = in_data_in;
      wp_next          = ~wp_reg;
    end
    if (pop) begin
      rp_next = ~rp_reg;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 2'h1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 2'h1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'h0;
      for (int i = 0; i < `SFC_BUF_DEPTH; i++) begin
        mem_reg[i] <= `SFC_RESP_RST;
      end
    end else if (clk_en_in) begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
      mem_reg <= mem_next;
    end
  end
endmodule // sfc_buf2

// >>> verif/sfc_frame_check_checker.sv
// Port-level assertions of the serial frame checker.
`timescale 1ns/1ps
module sfc_frame_check_checker
  import sfc_pkg::*;
(
  input wire logic      ref_clk_in,
  input wire logic      srst_in,
  input wire logic      cs_n_in,
  input wire logic      so_oe_out,
  input wire logic      word_valid_out,
  input wire logic      word_ready_in,
  input wire sfc_byte_t word_data_out,
  input wire logic      frame_error_flag_out,
  input wire logic      overrun_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  oe_release_a: assert property (cs_n_in [*4] |-> !so_oe_out)
    else $error("serial out driven while deselected");
  oe_drive_a: assert property (!cs_n_in [*4] |-> so_oe_out)
    else $error("serial out not driven while selected");
  word_hold_a: assert property (word_valid_out && !word_ready_in
    |=> word_valid_out && $stable(word_data_out)) else $error("word lost while stalled");
  flag_frame_a: assert property (!cs_n_in [*8] |=> $stable(frame_error_flag_out))
    else $error("error flag moved inside a frame");
  word_close_a: assert property ($rose(word_valid_out) |-> $past(cs_n_in, 4))
    else $error("word delivered before select rose");
  flag_clear_a: assert property ($rose(word_valid_out) |-> ##[0:3] !frame_error_flag_out)
    else $error("error flag kept after good frame");
  overrun_keep_a: assert property (overrun_out |=> overrun_out)
    else $error("overrun cleared without reset");
  reset_clear_a: assert property ($fell(srst_in)
    |-> !word_valid_out && !frame_error_flag_out && !overrun_out) else $error("reset state");
endmodule // sfc_frame_check_checker

bind sfc_frame_check sfc_frame_check_checker chk_u (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
  .cs_n_in(cs_n_in), .so_oe_out(so_oe_out), .word_valid_out(word_valid_out),
  .word_ready_in(word_ready_in), .word_data_out(word_data_out),
  .frame_error_flag_out(frame_error_flag_out), .overrun_out(overrun_out));

// >>> verif/sfc_spi_master.sv
// Serial master model driving select, serial clock and serial data.
`timescale 1ns/1ps
module sfc_spi_master (
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      si_out,
  input  wire logic so_in,
  input  wire logic so_oe_in
);
  logic idle = 1'b1;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end
  // An undriven data line must not look like the last bit, so it keeps toggling.
  always #6 if (idle) si_out = ~si_out;
  task automatic xfer(input logic [31:0] d, input int n, output logic first,
                      output logic [31:0] rx);
    rx = '0;
    // Clock noise while deselected must not disturb the next frame.
    repeat (3) begin
      #6 sclk_out = 1'b1;
      #6 sclk_out = 1'b0;
    end
    idle = 1'b0;
    si_out = (n > 0) ? d[n-1] : 1'b0;
    #20 cs_n_out = 1'b0;
    #130 first = so_oe_in ? so_in : 1'bx;
    for (int i = 0; i < n; i++) begin
      sclk_out = 1'b1;
      #6 rx = {rx[30:0], so_in};
      sclk_out = 1'b0;
      #6 si_out = (i < n - 1) ? d[n-2-i] : 1'b0;
    end
    #100 cs_n_out = 1'b1;
    idle = 1'b1;
  endtask
endmodule // sfc_spi_master

// >>> verif/sfc_frame_check_tb.sv
// Self-checking bench of the serial frame checker against a queue model.
`timescale 1ns/1ps
module sfc_frame_check_tb
  import sfc_pkg::*;
;
  logic        ref_clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        word_ready_in = 1'b0;
  logic        rdy_rand = 1'b0;
  logic        exp_flag = 1'b0;
  logic        exp_ov = 1'b0;
  logic        sclk, cs_n, si, so, so_oe, word_valid, flag, overrun, first;
  sfc_byte_t   resp_data = 8'h00;
  sfc_byte_t   word_data;
  logic [31:0] rx, e;
  int          n_fail = 0;
  int          checks_done = 0;
  sfc_byte_t   q[$];
  always #12.5 ref_clk_in = ~ref_clk_in;
  sfc_frame_check dut_u (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .clk_en_in(1'b1),
    .sclk_in(sclk), .cs_n_in(cs_n), .si_in(si), .so_out(so), .so_oe_out(so_oe),
    .resp_data_in(resp_data), .word_valid_out(word_valid), .word_ready_in(word_ready_in),
    .word_data_out(word_data), .frame_error_flag_out(flag), .overrun_out(overrun));
  sfc_spi_master mst_u (.sclk_out(sclk), .cs_n_out(cs_n), .si_out(si), .so_in(so),
    .so_oe_in(so_oe));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task end_of_test();
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(negedge ref_clk_in) word_ready_in <= rdy_rand & 1'($urandom_range(1));
  always @(posedge ref_clk_in) if (word_valid === 1'b1 && word_ready_in === 1'b1) begin
    check(word_data, (q.size() > 0) ? q[0] : 8'hXX);
    if (q.size() > 0) void'(q.pop_front());
  end
  task automatic frame(input int n);
    logic [31:0] d;
    d = $urandom;
    @(negedge ref_clk_in) resp_data = 8'($urandom);
    mst_u.xfer(d, n, first, rx);
    if (n > 0) check(first, exp_flag | d[n-1]);
    e = '0;
    for (int k = 1; k <= n; k++) e = {e[30:0], (k <= 8) ? resp_data[8-k] : d[n+8-k]};
    check(rx, e);
    // Only whole nonzero multiples of eight bits deliver a word.
    if (n % 8 == 0 && n > 0) begin
      exp_flag = 1'b0;
      if (q.size() < 3) q.push_back(d[7:0]);
      else exp_ov = 1'b1;
    end else exp_flag = 1'b1;
    repeat (14) @(negedge ref_clk_in);
    check(flag, exp_flag);
    check(overrun, exp_ov);
  endtask
  initial begin
    int lens[10] = '{8, 16, 5, 0, 8, 12, 24, 8, 1, 9};
    void'($urandom(14424));
    repeat (4) @(negedge ref_clk_in);
    srst_in = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    check({word_valid, flag, overrun, so_oe}, 4'h0);
    rdy_rand = 1'b1;
    foreach (lens[i]) frame(lens[i]);
    // Receiver stalls: the fourth word meets a full stage and buffer.
    rdy_rand = 1'b0;
    repeat (4) frame(8);
    rdy_rand = 1'b1;
    repeat (40) @(negedge ref_clk_in);
    check(q.size(), 0);
    frame(3);
    srst_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    srst_in = 1'b0;
    exp_flag = 1'b0;
    exp_ov = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    check({word_valid, flag, overrun}, 3'h0);
    frame(16);
    repeat (40) @(negedge ref_clk_in);
    check(q.size(), 0);
    end_of_test();
  end
  initial begin
    #60000;
    n_fail++;
    end_of_test();
  end
endmodule // sfc_frame_check_tb
